/* File: hdl/sar_ctl_pkg.sv */
// shared constants and carriers for the converter control block
package sar_ctl_pkg;
  localparam int RES_BITS = 10;
  localparam int NUM_CODES = 1024;
  // register word offsets (byte addresses)
  localparam logic [3:0] OFF_CTRL0 = 4'h0;
  localparam logic [3:0] OFF_CTRL1 = 4'h4;
  localparam logic [3:0] OFF_CTRL2 = 4'h8;
  localparam logic [3:0] OFF_RESULT = 4'hC;
  // converter_control_0 fields
  localparam int C0_ON = 0;
  localparam int C0_GO = 1;
  localparam int C0_CHS_LSB = 2;
  localparam int C0_IRQF = 6;
  localparam int C0_IRQE = 7;
  // converter_control_1 fields
  localparam int C1_PCFG_LSB = 0;
  localparam int C1_VREFN = 4;
  localparam int C1_VREFP = 5;
  // converter_control_2 fields
  localparam int C2_CS_LSB = 0;
  localparam int C2_ACQ_LSB = 3;
  localparam int C2_FMT = 7;
  // reset values
  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h00;
  // timing counts in conversion_bit_period units
  localparam logic [4:0] CONV_TADS = 5'h0B;
  localparam logic [4:0] GAP_TADS = 5'h02;
  // the rc source period, in core cycles at 25 MHz (roughly 1 us)
  localparam logic [6:0] RC_DIV = 7'h19;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACQ = 3'b001,
    ST_CONV = 3'b011,
    ST_GAP = 3'b010
  } sar_state_t;

  typedef struct packed {
    logic [3:0] chan;
    logic vref_pos_ext;
    logic vref_neg_ext;
    logic hold;
  } analog_ctl_t;

  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h1: acq_tads = 5'h02;
      3'h2: acq_tads = 5'h04;
      3'h3: acq_tads = 5'h06;
      3'h4: acq_tads = 5'h08;
      3'h5: acq_tads = 5'h0C;
      3'h6: acq_tads = 5'h10;
      3'h7: acq_tads = 5'h14;
      default: acq_tads = 5'h00;
    endcase
  endfunction
endpackage

/* File: hdl/tad_divider.sv */
// conversion_bit_period enable generator
`timescale 1ns/1ps
module tad_divider (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_run,
  input wire logic [2:0] i_sel,
  output logic o_tick
);
  logic [6:0] cnt;
  logic [6:0] lim;

  // divisor minus one; x11 selects the internal rc source
  always_comb begin
    case (i_sel)
      3'h0: lim = 7'h01;
      3'h4: lim = 7'h03;
      3'h1: lim = 7'h07;
      3'h5: lim = 7'h0F;
      3'h2: lim = 7'h1F;
      3'h6: lim = 7'h3F;
      default: lim = sar_ctl_pkg::RC_DIV - 7'h01;
    endcase
  end

  // held clear while not running, so the first bit period after leaving idle is full length
  always_ff @(posedge i_core_clk) begin
    if (i_srst || !i_run) begin
      cnt <= 7'h00;
      o_tick <= 1'b0;
    end else if (cnt >= lim) begin
      cnt <= 7'h00;
      o_tick <= 1'b1;
    end else begin
      cnt <= cnt + 7'h01;
      o_tick <= 1'b0;
    end
  end
endmodule

/* File: hdl/sar_adc_conversion_control.sv */
// successive-approximation converter control with avalon-mm registers
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
// What this block does
// - software picks supply rails or external pins as reference
// - rc conversion clock keeps converting while core is asleep
// - result built by successive approximation from held sample
// - reset restores registers, turns off converter, aborts conversion
// - each analog pin selectable as analog channel or digital io
// - completion loads result, clears start bit, sets irq flag
// - result pair not touched by reset
// - programmable acquisition inserted after start bit set
// - bit period per bit; two periods wait before next acquisition
// - result is ten bits, 1024 codes
// - a conversion takes eleven bit periods
// - clearing start bit aborts, result keeps previous value
// - acquisition code zero converts immediately; this is reset value
module sar_adc_conversion_control (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_sleep,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_cmp_high,
  output sar_ctl_pkg::analog_ctl_t o_analog,
  output logic [9:0] o_dac_code,
  output logic [12:0] o_pin_analog,
  output logic o_irq
);
  localparam int W = sar_ctl_pkg::RES_BITS;

  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [W-1:0] result;
  logic [W-1:0] trial;
  logic [4:0] tad_cnt;
  logic [4:0] bit_idx;
  sar_ctl_pkg::sar_state_t state;
  logic cmp_s1, cmp_s2, cmp_s3;
  logic tick;
  logic done_pulse;
  logic abort_pulse;
  logic run_div;
  logic acc;
  logic wr_go_clear;
  logic [W-1:0] next_trial;

  // reads are captured in the first cycle so data stands at the ack edge;
  // writes land only on the ack edge itself
  assign acc = (i_avs_read && o_avs_waitrequest) || (i_avs_write && !o_avs_waitrequest);
  assign wr_go_clear = acc && i_avs_write && i_avs_address == sar_ctl_pkg::OFF_CTRL0
    && i_avs_byteenable[0] && !i_avs_writedata[sar_ctl_pkg::C0_GO];
  // the core clock only counts in sleep when the rc source is chosen
  assign run_div = state != sar_ctl_pkg::ST_IDLE
    && (!i_sleep || ctrl2[1:0] == 2'b11);

  tad_divider u_div (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_run(run_div),
    .i_sel(ctrl2[2:0]),
    .o_tick(tick)
  );

  // comparator from the analog side, three stage synchroniser
  always_ff @(posedge i_core_clk) begin
    cmp_s1 <= i_cmp_high;
    cmp_s2 <= cmp_s1;
    cmp_s3 <= cmp_s2;
  end

  // one wait cycle per access keeps read data registered
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_avs_waitrequest <= 1'b1;
    end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_avs_readdata <= 32'h00000000;
    end else if (acc && i_avs_read) begin
      case (i_avs_address)
        sar_ctl_pkg::OFF_CTRL0: o_avs_readdata <= {24'h000000, ctrl0};
        sar_ctl_pkg::OFF_CTRL1: o_avs_readdata <= {24'h000000, ctrl1};
        sar_ctl_pkg::OFF_CTRL2: o_avs_readdata <= {24'h000000, ctrl2[7], 1'b0, ctrl2[5:0]};
        sar_ctl_pkg::OFF_RESULT: begin
          if (ctrl2[sar_ctl_pkg::C2_FMT]) begin
            o_avs_readdata <= {16'h0000, 6'h00, result[9:8], result[7:0]};
          end else begin
            o_avs_readdata <= {16'h0000, result, 6'h00};
          end
        end
        default: o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // go and the flag are hardware-owned; a set from hardware wins the cycle
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ctrl0 <= sar_ctl_pkg::RST_CTRL0;
    end else begin
      if (acc && i_avs_write && i_avs_address == sar_ctl_pkg::OFF_CTRL0
          && i_avs_byteenable[0]) begin
        ctrl0 <= i_avs_writedata[7:0];
        // go only starts when enabled and the converter is quiet
        ctrl0[sar_ctl_pkg::C0_GO] <= i_avs_writedata[sar_ctl_pkg::C0_GO]
          && i_avs_writedata[sar_ctl_pkg::C0_ON]
          && (ctrl0[sar_ctl_pkg::C0_GO] || state == sar_ctl_pkg::ST_IDLE);
      end
      if (done_pulse || abort_pulse) begin
        ctrl0[sar_ctl_pkg::C0_GO] <= 1'b0;
      end
      if (done_pulse) begin
        ctrl0[sar_ctl_pkg::C0_IRQF] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ctrl1 <= sar_ctl_pkg::RST_CTRL1;
      ctrl2 <= sar_ctl_pkg::RST_CTRL2;
    end else if (acc && i_avs_write && i_avs_byteenable[0]) begin
      if (i_avs_address == sar_ctl_pkg::OFF_CTRL1) begin
        ctrl1 <= i_avs_writedata[7:0];
      end
      if (i_avs_address == sar_ctl_pkg::OFF_CTRL2) begin
        ctrl2 <= {i_avs_writedata[7], 1'b0, i_avs_writedata[5:0]};
      end
    end
  end

  assign abort_pulse = state != sar_ctl_pkg::ST_IDLE && state != sar_ctl_pkg::ST_GAP
    && (wr_go_clear || !ctrl0[sar_ctl_pkg::C0_ON]);

  // sequencer: idle, acquire, convert, gap
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state <= sar_ctl_pkg::ST_IDLE;
      tad_cnt <= 5'h00;
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      unique case (state)
        sar_ctl_pkg::ST_IDLE: begin
          tad_cnt <= 5'h00;
          if (ctrl0[sar_ctl_pkg::C0_GO] && ctrl0[sar_ctl_pkg::C0_ON]) begin
            if (ctrl2[5:3] == 3'h0) begin
              state <= sar_ctl_pkg::ST_CONV;
            end else begin
              state <= sar_ctl_pkg::ST_ACQ;
            end
          end
        end
        sar_ctl_pkg::ST_ACQ: begin
          if (abort_pulse) begin
            state <= sar_ctl_pkg::ST_GAP;
            tad_cnt <= 5'h00;
          end else if (tick) begin
            if (tad_cnt + 5'h01 >= sar_ctl_pkg::acq_tads(ctrl2[5:3])) begin
              state <= sar_ctl_pkg::ST_CONV;
              tad_cnt <= 5'h00;
            end else begin
              tad_cnt <= tad_cnt + 5'h01;
            end
          end
        end
        sar_ctl_pkg::ST_CONV: begin
          if (abort_pulse) begin
            state <= sar_ctl_pkg::ST_GAP;
            tad_cnt <= 5'h00;
          end else if (tick) begin
            if (tad_cnt == sar_ctl_pkg::CONV_TADS - 5'h01) begin
              state <= sar_ctl_pkg::ST_GAP;
              tad_cnt <= 5'h00;
              done_pulse <= 1'b1;
            end else begin
              tad_cnt <= tad_cnt + 5'h01;
            end
          end
        end
        sar_ctl_pkg::ST_GAP: begin
          if (tick) begin
            if (tad_cnt == sar_ctl_pkg::GAP_TADS - 5'h01) begin
              state <= sar_ctl_pkg::ST_IDLE;
              tad_cnt <= 5'h00;
            end else begin
              tad_cnt <= tad_cnt + 5'h01;
            end
          end
        end
        default: state <= sar_ctl_pkg::ST_IDLE;
      endcase
    end
  end

  // bit period 0 settles; periods 1..10 decide bits 9..0
  assign bit_idx = 5'(W) - tad_cnt;
  always_comb begin
    next_trial = trial;
    if (tad_cnt >= 5'h01 && tad_cnt <= 5'(W)) begin
      if (!cmp_s3 && cmp_s2 == cmp_s3) begin
        next_trial[bit_idx[3:0]] = 1'b0;
      end
      if (bit_idx != 5'h00) begin
        next_trial[bit_idx[3:0] - 4'h1] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      trial <= 10'h200;
    end else if (state != sar_ctl_pkg::ST_CONV) begin
      trial <= 10'h200;
    end else if (tick) begin
      trial <= next_trial;
    end
  end

  // no reset term: contents survive any reset
  always_ff @(posedge i_core_clk) begin
    if (done_pulse) begin
      result <= trial;
    end else if (acc && i_avs_write && i_avs_address == sar_ctl_pkg::OFF_RESULT) begin
      if (i_avs_byteenable[0]) begin
        result[7:0] <= i_avs_writedata[7:0];
      end
      if (i_avs_byteenable[1]) begin
        result[9:8] <= i_avs_writedata[9:8];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_analog <= '0;
      o_dac_code <= 10'h000;
      o_pin_analog <= 13'h0000;
      o_irq <= 1'b0;
    end else begin
      o_analog.chan <= ctrl0[5:2];
      o_analog.vref_pos_ext <= ctrl1[sar_ctl_pkg::C1_VREFP];
      o_analog.vref_neg_ext <= ctrl1[sar_ctl_pkg::C1_VREFN];
      o_analog.hold <= state == sar_ctl_pkg::ST_IDLE ? 1'b0 :
        (state == sar_ctl_pkg::ST_CONV);
      o_dac_code <= trial;
      // pcfg n: channels below 15-n are analog
      for (int k = 0; k < 13; k++) begin
        o_pin_analog[k] <= 4'(k) < 4'hF - ctrl1[3:0];
      end
      o_irq <= ctrl0[sar_ctl_pkg::C0_IRQF] && ctrl0[sar_ctl_pkg::C0_IRQE];
    end
  end

  a_go_stays: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (state == sar_ctl_pkg::ST_CONV && !done_pulse && !abort_pulse
     && !$past(done_pulse)) |-> ctrl0[sar_ctl_pkg::C0_GO])
    else $error("start bit dropped during conversion");
  a_done_flag: assert property (@(posedge i_core_clk) disable iff (i_srst)
    done_pulse |=> ctrl0[sar_ctl_pkg::C0_IRQF] && !ctrl0[sar_ctl_pkg::C0_GO]
      && result == $past(trial))
    else $error("completion effects missing");
  a_abort_keeps: assert property (@(posedge i_core_clk) disable iff (i_srst)
    abort_pulse && !(acc && i_avs_write && i_avs_address == sar_ctl_pkg::OFF_RESULT)
      |=> result == $past(result))
    else $error("abort changed result");
  a_gap_after: assert property (@(posedge i_core_clk) disable iff (i_srst)
    done_pulse |-> state == sar_ctl_pkg::ST_GAP ##1 state == sar_ctl_pkg::ST_GAP)
    else $error("no gap after conversion");
  a_manual_start: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (state == sar_ctl_pkg::ST_IDLE && ctrl0[1] && ctrl0[0] && ctrl2[5:3] == 3'h0)
      |=> state == sar_ctl_pkg::ST_CONV)
    else $error("manual mode did not convert at once");
  a_auto_acq: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (state == sar_ctl_pkg::ST_IDLE && ctrl0[1] && ctrl0[0] && ctrl2[5:3] != 3'h0)
      |=> state == sar_ctl_pkg::ST_ACQ)
    else $error("acquisition phase skipped");
  a_conv_len: assert property (@(posedge i_core_clk) disable iff (i_srst)
    done_pulse |-> $past(tad_cnt) == sar_ctl_pkg::CONV_TADS - 5'h01)
    else $error("conversion length wrong");
  a_hold_conv: assert property (@(posedge i_core_clk) disable iff (i_srst)
    $rose(state == sar_ctl_pkg::ST_CONV) |=> o_analog.hold)
    else $error("capacitor still connected");
  a_reset_off: assert property (@(posedge i_core_clk)
    i_srst |=> ctrl0 == 8'h00 && state == sar_ctl_pkg::ST_IDLE)
    else $error("reset did not stop converter");
  c_done: cover property (@(posedge i_core_clk) disable iff (i_srst) done_pulse);
  c_abort: cover property (@(posedge i_core_clk) disable iff (i_srst) abort_pulse);
  c_acq: cover property (@(posedge i_core_clk) disable iff (i_srst)
    state == sar_ctl_pkg::ST_ACQ ##1 state == sar_ctl_pkg::ST_CONV);
  c_sleep: cover property (@(posedge i_core_clk) disable iff (i_srst) i_sleep && tick);
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_sleep = 1'b0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic i_cmp_high = 1'b0;
  logic [3:0] i_avs_address = 4'h0;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [31:0] o_avs_readdata;
  logic [31:0] rd;
  logic o_avs_waitrequest;
  logic o_irq;
  sar_ctl_pkg::analog_ctl_t o_analog;
  logic [9:0] o_dac_code;
  logic [9:0] tgt = 10'h000;
  logic [12:0] o_pin_analog;
  logic [12:0] exp_pins;
  logic [9:0] codes [8] = '{10'h000, 10'h3FF, 10'h2A5, 10'h155, 10'h200, 10'h1FF, 10'h001, 10'h3FE};
  int acq_periods [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int fails = 0;
  int cmp_count = 0;
  int cyc;
  int lo;

  sar_adc_conversion_control i_sar_adc_conversion_control (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_sleep(i_sleep),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_cmp_high(i_cmp_high),
    .o_analog(o_analog),
    .o_dac_code(o_dac_code),
    .o_pin_analog(o_pin_analog),
    .o_irq(o_irq)
  );

  initial begin
    forever #20 i_core_clk = ~i_core_clk;
  end

  // ideal comparator: held sample against the trial code
  always @(posedge i_core_clk) begin
    i_cmp_high <= (tgt >= o_dac_code);
  end

  task automatic report_and_stop;
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one bus access; the edge first keeps a release and a new request apart
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= ~w;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      fails++;
    end
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  // clears the flag, starts, checks the capacitor switch, then times completion
  task automatic convert(input logic [7:0] c0, input logic exp_hold);
    acc(1'b1, 4'h0, {24'h0, c0 & 8'hBD});
    repeat (3) @(posedge i_core_clk);
    acc(1'b1, 4'h0, {24'h0, c0});
    repeat (16) @(posedge i_core_clk);
    chk("hold", {31'h0, exp_hold}, {31'h0, o_analog.hold});
    cyc = 16;
    while (o_irq !== 1'b1 && cyc < 2000) begin
      @(posedge i_core_clk);
      cyc++;
    end
  endtask

  initial begin
    repeat (12) @(posedge i_core_clk);
    i_srst <= 1'b0;
    rchk("ctrl0 reset", 4'h0, 32'h0);
    rchk("ctrl2 reset", 4'h8, 32'h0);
    acc(1'b1, 4'h2, 32'hFF);
    rchk("unmapped", 4'h2, 32'h0);
    for (int n = 0; n < 16; n++) begin
      acc(1'b1, 4'h4, 32'h30 | n);
      rchk("ctrl1", 4'h4, 32'h30 | n);
      for (int k = 0; k < 13; k++) begin
        exp_pins[k] = (k < 15 - n);
      end
      chk("pins", {19'h0, exp_pins}, {19'h0, o_pin_analog});
      chk("vref", 32'h3, {30'h0, o_analog.vref_pos_ext, o_analog.vref_neg_ext});
    end
    acc(1'b1, 4'h4, 32'h10);
    repeat (3) @(posedge i_core_clk);
    chk("vref", 32'h1, {30'h0, o_analog.vref_pos_ext, o_analog.vref_neg_ext});
    acc(1'b1, 4'h0, 32'h02);
    rchk("go while off", 4'h0, 32'h0);
    acc(1'b1, 4'h0, 32'h01);
    for (int a = 0; a < 8; a++) begin
      tgt = codes[a];
      acc(1'b1, 4'h8, {24'h0, a[0], 1'b0, a[2:0], 3'b010});
      convert({1'b1, 1'b0, a[3:0], 2'b11}, a == 0);
      lo = (acq_periods[a] + 11) * 32;
      chk("cycles", 32'h1, {31'h0, cyc >= lo && cyc <= lo + 24});
      chk("chan", a, {28'h0, o_analog.chan});
      rchk("result", 4'hC, a[0] ? {22'h0, tgt} : {16'h0, tgt, 6'h0});
      rchk("ctrl0 done", 4'h0, {24'h0, 2'b11, a[3:0], 2'b01});
      if (a == 0) begin
        acc(1'b1, 4'h0, 32'h03);
        rchk("go in gap", 4'h0, 32'h01);
      end
      repeat (3 * 32) @(posedge i_core_clk);
    end
    tgt = 10'h0F0;
    acc(1'b1, 4'h8, 32'h82);
    acc(1'b1, 4'h0, 32'h03);
    repeat (100) @(posedge i_core_clk);
    acc(1'b1, 4'h0, 32'h01);
    rchk("ctrl0 abort", 4'h0, 32'h01);
    rchk("result abort", 4'hC, {22'h0, codes[7]});
    chk("irq abort", 32'h0, {31'h0, o_irq});
    repeat (3 * 32) @(posedge i_core_clk);
    acc(1'b1, 4'hC, 32'h155);
    rchk("result written", 4'hC, 32'h155);
    // rc source must keep counting while the core sleeps
    i_sleep <= 1'b1;
    tgt = 10'h2C3;
    acc(1'b1, 4'h8, 32'h83);
    convert(8'h83 | 8'h80, 1'b1);
    chk("rc cycles", 32'h1, {31'h0, cyc >= 11 * 25 && cyc <= 11 * 25 + 24});
    rchk("rc result", 4'hC, {22'h0, tgt});
    chk("dac idle", 32'h200, {22'h0, o_dac_code});
    i_sleep <= 1'b0;
    repeat (3 * 32) @(posedge i_core_clk);
    tgt = 10'h111;
    acc(1'b1, 4'h8, 32'h82);
    acc(1'b1, 4'h0, 32'h03);
    repeat (100) @(posedge i_core_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_srst <= 1'b0;
    rchk("ctrl0 after reset", 4'h0, 32'h0);
    rchk("ctrl2 after reset", 4'h8, 32'h0);
    chk("hold after reset", 32'h0, {31'h0, o_analog.hold});
    rchk("result kept", 4'hC, {16'h0, 10'h2C3, 6'h0});
    report_and_stop();
  end

  initial begin
    repeat (60000) @(posedge i_core_clk);
    fails++;
    report_and_stop();
  end
endmodule
